// file: core/speech_payload_classifier.sv
// Speech payload classifier: size-based mode decode, field parse, RTP fields
//
// Summary of operation
// - Primary-mode bitrate follows only from compact payload length; 48 bits is silence.
// - Nine legacy lengths map to legacy-interoperable rates; 56 bits is ambiguous.
// - Compact primary payload is one frame, first encoder bit leftmost.
// - Compact legacy payload is 3-bit rate request, frame, then zero pad.
// - Timestamp runs at 16 kHz, advancing 320 per 20 ms frame-block.
// - Marker is one only when first frame-block starts a talkspurt.
// - Bytes most significant first, bits most significant first.
// - Every primary silence descriptor is exactly 48 bits, two variants.
// - Frequency-domain descriptor: flag, 2-bit band, rate bit, 7-bit gain, energies.
// - Scheme flag, band code and core rate bit select their meanings.
// - Linear-prediction descriptor: flag, band bit, rate bit, 3-bit hangover, spectra.
// - Band bit picks WB or SWB; hangover counts preceding hangover frames.
// - Channel-aware index sits in the first five frame bits.
// - Last three bits are redundant type, two before them the offset.
// - Offset gives distance 2, 3, 5 or 7; type has eight kinds.
// - With redundancy flag clear the frame is plain 13.2 kbps.
// - 48 kbps is transform only; high rates fixed at 960 to 2560 bits.
// - At 64 kbps first bit picks linear-prediction or high-quality transform.
// - High-quality transform: previous-core bit, then rate bit only if set.
// - Legacy-interoperable frames are recognised for the older payload format.
// - Compact and header-full payloads may mix; header-full only is selectable.
// - For 56 bits, first bit zero is primary 2.8, one is legacy silence.
// - Header-full first byte MSB: zero contents byte, one rate request.
// - Legacy pad is one bit at 6.6, four at 8.85, else none.
`timescale 1ns/1ns
`default_nettype none
`include "speech_cls_cfg.svh"

module speech_payload_classifier (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	// Received payload bytes from the packet transport
	input  wire logic                        payValid,
	input  wire speech_cls_pkg::payByte_t    payByte,
	// Classification towards the codec core and jitter buffer
	output var  logic                        resValid,
	output var  speech_cls_pkg::classResult_t result,
	output var  logic                        resError,
	// RTP header fields for the sending side
	input  wire logic                        frameTick,
	input  wire logic                        pktSend,
	input  wire logic                        talkspurtFirst,
	output var  logic [31:0]                 rtpTimestamp,
	output var  logic                        rtpMarker,
	// AXI4-Lite slave
	input  wire logic [4:0]                  awaddr,
	input  wire logic                        awvalid,
	output var  logic                        awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output var  logic                        wready,
	output var  logic [1:0]                  bresp,
	output var  logic                        bvalid,
	input  wire logic                        bready,
	input  wire logic [4:0]                  araddr,
	input  wire logic                        arvalid,
	output var  logic                        arready,
	output var  logic [31:0]                 rdata,
	output var  logic [1:0]                  rresp,
	output var  logic                        rvalid,
	input  wire logic                        rready
);
	import speech_cls_pkg::*;

	// ------------------------------------------------------------
	// Payload capture
	// ------------------------------------------------------------
	logic [8:0]   byteCnt_q;
	logic [7:0]   hdr_q [`HDR_BYTES];
	logic [7:0]   tail_q;
	logic [11:0]  lenBits_q;
	logic         pend_q;
	logic [2:0]   ctrl_q;
	logic [15:0]  errCnt_q;
	classResult_t res_d;
	logic         err_d;

	// Bytes arrive in order, so byte 0 bit 7 is the first payload bit
	generate
		for (genvar i = 0; i < `HDR_BYTES; i++) begin : g_hdr
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					hdr_q[i] <= 8'h00;
				end else if (payValid && byteCnt_q == 9'(i)) begin
					hdr_q[i] <= payByte.data;
				end
			end
		end
	endgenerate

	// Longer payloads saturate so they can never alias a protected size
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			byteCnt_q <= 9'h000;
			tail_q    <= 8'h00;
			lenBits_q <= 12'h000;
			pend_q    <= 1'b0;
		end else begin
			pend_q <= payValid && payByte.last;
			if (payValid) begin
				tail_q <= payByte.data;
				if (payByte.last) begin
					byteCnt_q <= 9'h000;
					lenBits_q <= (byteCnt_q == 9'h1FF) ? 12'hFFF
						: {byteCnt_q + 9'h001, 3'h0};
				end else if (byteCnt_q != 9'h1FF) begin
					byteCnt_q <= byteCnt_q + 9'h001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Classification
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] b0;
		logic [7:0] b1;
		logic       known;
		b0    = hdr_q[0];
		b1    = hdr_q[1];
		known = 1'b1;
		err_d = 1'b0;
		res_d = '0;
		res_d.kind       = KIND_PRIM;
		res_d.lengthBits = lenBits_q;
		res_d.redundType = REDUND_NONE;
		// Rates in hundredths of kbps
		case (lenBits_q)
			`LEN_PRIM_SIL: begin
				res_d.kind      = KIND_PRIM_SIL;
				res_d.rateCenti = 14'h00F0;
			end
			`LEN_AMBIG: begin
				if (b0[7]) begin
					res_d.kind = KIND_LEGACY_SIL_HF;
					res_d.hdrIsRequest = 1'b1;
				end else begin
					res_d.rateCenti = 14'h0118;
				end
			end
			`LEN_PRIM_7K2:  res_d.rateCenti = 14'h02D0;
			`LEN_PRIM_8K0:  res_d.rateCenti = 14'h0320;
			`LEN_PRIM_9K6:  res_d.rateCenti = 14'h03C0;
			`LEN_PRIM_13K2: res_d.rateCenti = 14'h0528;
			`LEN_PRIM_16K4: res_d.rateCenti = 14'h0668;
			`LEN_PRIM_24K4: res_d.rateCenti = 14'h0988;
			`LEN_PRIM_32K:  res_d.rateCenti = 14'h0C80;
			`LEN_PRIM_48K:  res_d.rateCenti = 14'h12C0;
			`LEN_PRIM_64K:  res_d.rateCenti = 14'h1900;
			`LEN_PRIM_96K:  res_d.rateCenti = 14'h2580;
			`LEN_PRIM_128K: res_d.rateCenti = 14'h3200;
			`LEN_LEG_6K6:   res_d.rateCenti = 14'h0294;
			`LEN_LEG_8K85:  res_d.rateCenti = 14'h0375;
			`LEN_LEG_12K65: res_d.rateCenti = 14'h04F1;
			`LEN_LEG_14K25: res_d.rateCenti = 14'h0591;
			`LEN_LEG_15K85: res_d.rateCenti = 14'h0631;
			`LEN_LEG_18K25: res_d.rateCenti = 14'h0721;
			`LEN_LEG_19K85: res_d.rateCenti = 14'h07C1;
			`LEN_LEG_23K05: res_d.rateCenti = 14'h0901;
			`LEN_LEG_23K85: res_d.rateCenti = 14'h0951;
			default:        known = 1'b0;
		endcase
		// Legacy sizes carry the 3-bit rate request ahead of the frame
		case (lenBits_q)
			`LEN_LEG_6K6, `LEN_LEG_8K85, `LEN_LEG_12K65, `LEN_LEG_14K25,
			`LEN_LEG_15K85, `LEN_LEG_18K25, `LEN_LEG_19K85,
			`LEN_LEG_23K05, `LEN_LEG_23K85: begin
				res_d.kind        = KIND_LEGACY;
				res_d.rateRequest = b0[7:5];
				res_d.padBits = (lenBits_q == `LEN_LEG_6K6) ? `PAD_6K6
					: (lenBits_q == `LEN_LEG_8K85) ? `PAD_8K85 : 3'h0;
			end
			default: ;
		endcase
		// Silence descriptor: scheme flag selects the field layout
		if (res_d.kind == KIND_PRIM_SIL) begin
			res_d.silLpScheme = b0[7];
			if (!b0[7]) begin
				res_d.silBand     = b0[6:5];
				res_d.silRateHigh = b0[4];
				res_d.silGain     = {b0[3:0], b1[7:5]};
			end else begin
				res_d.silBand     = {1'b0, b0[6]};
				res_d.silRateHigh = b0[5];
				res_d.silHangover = b0[4:2];
			end
		end
		// Channel-aware framing is only known by session setup
		if (lenBits_q == `LEN_PRIM_13K2 && ctrl_q[`CTRL_CHAN_AWARE]) begin
			res_d.chanIdx    = b0[7:3];
			res_d.redundFlag = b0[3];
			if (b0[3]) begin
				unique case (tail_q[4:3])
					2'h0: res_d.redundOffset = 3'h2;
					2'h1: res_d.redundOffset = 3'h3;
					2'h2: res_d.redundOffset = 3'h5;
					2'h3: res_d.redundOffset = 3'h7;
				endcase
				res_d.redundType = redundType_t'(tail_q[2:0]);
			end
		end
		res_d.xformOnly = (lenBits_q == `LEN_PRIM_48K);
		if (lenBits_q == `LEN_PRIM_64K) begin
			res_d.hiqCore = b0[7];
			if (b0[7]) begin
				res_d.prevLp         = b0[6];
				res_d.prevLpRateHigh = b0[6] & b0[5];
			end else begin
				res_d.chanIdx = b0[6:2];
			end
		end
		// Unknown sizes are header-full when allowed, else dropped
		if (ctrl_q[`CTRL_HF_ONLY] || !known) begin
			res_d.kind         = KIND_HDR_FULL;
			res_d.hdrIsRequest = b0[7];
			res_d.rateCenti    = 14'h0000;
			err_d = !ctrl_q[`CTRL_HF_ONLY] && !ctrl_q[`CTRL_ACCEPT_HF];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			resValid <= 1'b0;
			resError <= 1'b0;
			result   <= '0;
			errCnt_q <= 16'h0000;
		end else begin
			resValid <= pend_q && !err_d;
			resError <= pend_q && err_d;
			if (pend_q && !err_d) begin
				result <= res_d;
			end
			if (pend_q && err_d && errCnt_q != 16'hFFFF) begin
				errCnt_q <= errCnt_q + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// RTP timestamp and marker
	// ------------------------------------------------------------
	logic        wrDo;
	logic [4:0]  awAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;

	// A software write to the timestamp wins over a frame tick
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rtpTimestamp <= 32'h0000_0000;
		end else if (wrDo && awAddr_q == `ADDR_TSTAMP) begin
			for (int k = 0; k < 4; k++) begin
				if (wStrb_q[k]) begin
					rtpTimestamp[8*k +: 8] <= wData_q[8*k +: 8];
				end
			end
		end else if (frameTick) begin
			rtpTimestamp <= rtpTimestamp + `TS_STEP;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rtpMarker <= 1'b0;
		end else if (pktSend) begin
			rtpMarker <= talkspurtFirst;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign wrDo = !awready && !wready && !bvalid;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= `RESP_OKAY;
			awAddr_q <= 5'h00;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready  <= 1'b0;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready  <= 1'b0;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (wrDo) begin
				bvalid <= 1'b1;
				bresp  <= (awAddr_q == `ADDR_CTRL
					|| awAddr_q == `ADDR_TSTAMP) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `CTRL_RESET;
		end else if (wrDo && awAddr_q == `ADDR_CTRL && wStrb_q[0]) begin
			ctrl_q <= wData_q[2:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `RESP_OKAY;
			case (araddr)
				`ADDR_CTRL:   rdata <= {29'h0, ctrl_q};
				`ADDR_STATUS: rdata <= {errCnt_q, 13'h0, result.kind};
				`ADDR_LENGTH: rdata <= {2'h0, result.rateCenti,
					4'h0, result.lengthBits};
				`ADDR_FIELDS: rdata <= {result.hdrIsRequest,
					result.prevLpRateHigh, result.prevLp, result.hiqCore,
					result.xformOnly, result.padBits, result.rateRequest,
					result.silLpScheme, result.silBand, result.silRateHigh,
					result.silGain, result.silHangover, 7'h00};
				`ADDR_TSTAMP: rdata <= rtpTimestamp;
				`ADDR_REDUND: rdata <= {20'h0, result.chanIdx,
					result.redundFlag, result.redundOffset, result.redundType};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_ts_step;
		@(posedge ref_clk) disable iff (!nrst)
		frameTick && !wrDo |=> rtpTimestamp == $past(rtpTimestamp) + 32'd320;
	endproperty
	a_ts_step: assert property (p_ts_step)
		else $error("timestamp did not advance by one frame-block");

	property p_marker;
		@(posedge ref_clk) disable iff (!nrst)
		pktSend |=> rtpMarker == $past(talkspurtFirst);
	endproperty
	a_marker: assert property (p_marker)
		else $error("marker does not follow talkspurt start");

	// Back-to-back packets are legal, so the hold is checked per cycle
	property p_marker_hold;
		@(posedge ref_clk) disable iff (!nrst)
		!pktSend |=> $stable(rtpMarker);
	endproperty
	a_marker_hold: assert property (p_marker_hold)
		else $error("marker changed without a packet");

	property p_sil_len;
		@(posedge ref_clk) disable iff (!nrst)
		resValid && result.kind == KIND_PRIM_SIL |-> result.lengthBits == 12'd48;
	endproperty
	a_sil_len: assert property (p_sil_len)
		else $error("silence descriptor with wrong length");

	property p_legacy_len;
		@(posedge ref_clk) disable iff (!nrst)
		resValid && result.kind == KIND_LEGACY |-> result.lengthBits inside
			{12'd136, 12'd184, 12'd256, 12'd288, 12'd320, 12'd368,
			 12'd400, 12'd464, 12'd480};
	endproperty
	a_legacy_len: assert property (p_legacy_len)
		else $error("legacy class for a non-legacy size");

	property p_pad;
		@(posedge ref_clk) disable iff (!nrst)
		resValid && result.kind == KIND_LEGACY |-> result.padBits ==
			(result.lengthBits == 12'd136 ? 3'd1
			: result.lengthBits == 12'd184 ? 3'd4 : 3'd0);
	endproperty
	a_pad: assert property (p_pad)
		else $error("wrong legacy padding count");

	property p_latency;
		@(posedge ref_clk) disable iff (!nrst)
		payValid && payByte.last |-> ##2 (resValid ^ resError);
	endproperty
	a_latency: assert property (p_latency)
		else $error("payload end not answered two cycles later");

	property p_redund_off;
		@(posedge ref_clk) disable iff (!nrst)
		resValid && !result.redundFlag |-> result.redundOffset == 3'd0
			&& result.redundType == REDUND_NONE;
	endproperty
	a_redund_off: assert property (p_redund_off)
		else $error("redundancy fields set with flag clear");

	property p_offset;
		@(posedge ref_clk) disable iff (!nrst)
		resValid && result.redundFlag |->
			result.redundOffset inside {3'd2, 3'd3, 3'd5, 3'd7};
	endproperty
	a_offset: assert property (p_offset)
		else $error("illegal redundant frame distance");

	property p_err_drop;
		@(posedge ref_clk) disable iff (!nrst)
		resError |-> !resValid ##1 $stable(result);
	endproperty
	a_err_drop: assert property (p_err_drop)
		else $error("errored payload was not discarded");

	c_silence: cover property (@(posedge ref_clk) disable iff (!nrst)
		resValid && result.kind == KIND_PRIM_SIL);
	c_chan_aware: cover property (@(posedge ref_clk) disable iff (!nrst)
		resValid && result.redundFlag);
	c_error: cover property (@(posedge ref_clk) disable iff (!nrst)
		resError);
	c_ambig: cover property (@(posedge ref_clk) disable iff (!nrst)
		resValid && result.kind == KIND_LEGACY_SIL_HF);

endmodule : speech_payload_classifier
`default_nettype wire

// file: core/speech_cls_cfg.svh
// Offsets, field positions, sizes and counts of the speech payload classifier
`ifndef SPEECH_CLS_CFG_SVH
`define SPEECH_CLS_CFG_SVH

// ----------------------------------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_CTRL        5'h00
`define ADDR_STATUS      5'h04
`define ADDR_LENGTH      5'h08
`define ADDR_FIELDS      5'h0C
`define ADDR_TSTAMP      5'h10
`define ADDR_REDUND      5'h14

// ----------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------
`define CTRL_HF_ONLY     0
`define CTRL_ACCEPT_HF   1
`define CTRL_CHAN_AWARE  2
`define CTRL_RESET       3'h2

// ----------------------------------------------------------------
// Protected payload sizes in bits
// ----------------------------------------------------------------
`define LEN_PRIM_SIL     12'h030
`define LEN_AMBIG        12'h038
`define LEN_LEG_6K6      12'h088
`define LEN_PRIM_7K2     12'h090
`define LEN_PRIM_8K0     12'h0A0
`define LEN_LEG_8K85     12'h0B8
`define LEN_PRIM_9K6     12'h0C0
`define LEN_LEG_12K65    12'h100
`define LEN_PRIM_13K2    12'h108
`define LEN_LEG_14K25    12'h120
`define LEN_LEG_15K85    12'h140
`define LEN_PRIM_16K4    12'h148
`define LEN_LEG_18K25    12'h170
`define LEN_LEG_19K85    12'h190
`define LEN_LEG_23K05    12'h1D0
`define LEN_LEG_23K85    12'h1E0
`define LEN_PRIM_24K4    12'h1E8
`define LEN_PRIM_32K     12'h280
`define LEN_PRIM_48K     12'h3C0
`define LEN_PRIM_64K     12'h500
`define LEN_PRIM_96K     12'h780
`define LEN_PRIM_128K    12'hA00

// ----------------------------------------------------------------
// Padding, timestamp and bus answers
// ----------------------------------------------------------------
`define PAD_6K6          3'h1
`define PAD_8K85         3'h4
`define TS_CLOCK_HZ      16000
`define FRAME_MS         20
`define TS_STEP          32'((`TS_CLOCK_HZ * `FRAME_MS) / 1000)
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define HDR_BYTES        2

`endif

// file: core/speech_cls_pkg.sv
// Types shared by the speech payload classifier and its bench
`default_nettype none
package speech_cls_pkg;

	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_PRIM,
		KIND_PRIM_SIL,
		KIND_LEGACY,
		KIND_LEGACY_SIL_HF,
		KIND_HDR_FULL
	} payloadKind_t;

	typedef enum logic [2:0] {
		REDUND_NONE,
		REDUND_XFORM_FREQ,
		REDUND_XFORM_TIME_A,
		REDUND_XFORM_TIME_B,
		REDUND_FULL_PREDICT,
		REDUND_NO_PREDICT,
		REDUND_GENERIC_PREDICT,
		REDUND_NOISE_EXCITED
	} redundType_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} payByte_t;

	typedef struct packed {
		payloadKind_t kind;
		logic [13:0]  rateCenti;
		logic [11:0]  lengthBits;
		logic [2:0]   padBits;
		logic [2:0]   rateRequest;
		logic         silLpScheme;
		logic [1:0]   silBand;
		logic         silRateHigh;
		logic [6:0]   silGain;
		logic [2:0]   silHangover;
		logic [4:0]   chanIdx;
		logic         redundFlag;
		logic [2:0]   redundOffset;
		redundType_t  redundType;
		logic         xformOnly;
		logic         hiqCore;
		logic         prevLp;
		logic         prevLpRateHigh;
		logic         hdrIsRequest;
	} classResult_t;

endpackage : speech_cls_pkg
`default_nettype wire

// file: sim/payload_source.sv
// Packet transport model that streams payload bytes into the classifier
`timescale 1ns/1ns
`default_nettype none
module payload_source (
	// Clock
	input  wire logic                     ref_clk,
	// Payload byte stream
	output var  logic                     payValid,
	output var  speech_cls_pkg::payByte_t payByte
);
	import speech_cls_pkg::*;

	logic busy;

	initial begin
		busy = 1'b0;
		payValid = 1'b0;
		payByte = '0;
	end

	// ----------------------------------------------------------------
	// Idle lines
	// ----------------------------------------------------------------
	// Data wanders while idle so a stale byte never looks like a fresh one
	always @(posedge ref_clk) begin
		if (!busy) begin
			payByte.data <= ~payByte.data;
		end
	end

	// ----------------------------------------------------------------
	// Frame sender
	// ----------------------------------------------------------------
	// First coded bit sits in the MSB of byte zero, bytes go MSB first
	task automatic send(input int n, input logic [7:0] b0, input logic [7:0] bl);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			busy = 1'b1;
			payValid <= 1'b1;
			payByte.data <= (i == 0) ? b0 : (i == n - 1) ? bl : 8'(i);
			payByte.last <= (i == n - 1);
		end
		@(posedge ref_clk);
		payValid <= 1'b0;
		busy = 1'b0;
	endtask : send
endmodule : payload_source
`default_nettype wire

// file: sim/speech_payload_classifier_tb.sv
// Self-checking bench for the speech payload classifier
`timescale 1ns/1ns
`default_nettype none
`include "speech_cls_cfg.svh"
module speech_payload_classifier_tb;
	import speech_cls_pkg::*;

	logic         ref_clk, nrst, payValid, resValid, resError;
	payByte_t     payByte;
	classResult_t result;
	logic         frameTick, pktSend, talkspurtFirst, rtpMarker;
	logic [31:0]  rtpTimestamp, wdata, rdata, rd;
	logic [4:0]   awaddr, araddr;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp, rsp;
	logic         awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready;
	int           mismatches, cmp_count, cycleCount;
	int           nb[7] = '{6, 18, 17, 23, 61, 320, 36};
	int           rc[7] = '{240, 720, 660, 885, 2440, 12800, 1425};
	int           pd[7] = '{0, 0, 1, 4, 0, 0, 0};
	int           od[4] = '{2, 3, 5, 7};
	logic [2:0]   kd[7] = '{KIND_PRIM_SIL, KIND_PRIM, KIND_LEGACY, KIND_LEGACY,
		KIND_PRIM, KIND_PRIM, KIND_LEGACY};

	always #4 ref_clk = ~ref_clk;

	speech_payload_classifier dut (.ref_clk(ref_clk), .nrst(nrst),
		.payValid(payValid), .payByte(payByte), .resValid(resValid),
		.result(result), .resError(resError), .frameTick(frameTick),
		.pktSend(pktSend), .talkspurtFirst(talkspurtFirst),
		.rtpTimestamp(rtpTimestamp), .rtpMarker(rtpMarker), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	payload_source src (.ref_clk(ref_clk), .payValid(payValid),
		.payByte(payByte));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [4:0] a);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axr

	// Send returns on the edge taking the last byte; the answer stands
	// for one cycle after the next edge only
	task automatic pay(input int n, input logic [7:0] b0, input logic [7:0] bl);
		src.send(n, b0, bl);
		@(posedge ref_clk);
		#1;
	endtask : pay

	task automatic pulse(input logic mk, input logic t);
		@(posedge ref_clk);
		if (mk) pktSend <= 1'b1;
		else frameTick <= 1'b1;
		talkspurtFirst <= t;
		@(posedge ref_clk);
		pktSend <= 1'b0;
		frameTick <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : pulse

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	always @(posedge ref_clk) begin
		cycleCount++;
		if (cycleCount == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		{frameTick, pktSend, talkspurtFirst} = 3'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		mismatches = 0;
		cmp_count = 0;
		cycleCount = 0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		axr(`ADDR_CTRL);
		chk(rd, 32'h2);
		axr(5'h1C);
		chk(rsp, 2'h2);
		chk(rd, 32'h0);
		axw(`ADDR_STATUS, 32'hFFFF);
		chk(rsp, 2'h2);
		done("bus");
		for (int i = 0; i < 7; i++) begin
			pay(nb[i], 8'hA0, 8'h00);
			chk(resValid, 32'h1);
			chk(result.kind, kd[i]);
			chk(result.rateCenti, rc[i]);
			chk(result.lengthBits, nb[i] * 8);
			chk(result.padBits, pd[i]);
			if (kd[i] == KIND_LEGACY) chk(result.rateRequest, 32'h5);
		end
		pay(7, 8'h40, 8'h00);
		chk(result.kind, KIND_PRIM);
		chk(result.rateCenti, 32'd280);
		pay(7, 8'hC0, 8'h00);
		chk(result.kind, KIND_LEGACY_SIL_HF);
		done("sizes");
		pay(6, 8'h3A, 8'h00);
		chk({result.silLpScheme, result.silBand, result.silRateHigh}, 32'h3);
		chk(result.silGain, 32'h50);
		pay(6, 8'hD4, 8'h00);
		chk(result.kind, KIND_PRIM_SIL);
		chk({result.silLpScheme, result.silBand, result.silRateHigh}, 32'hA);
		chk(result.silHangover, 32'h5);
		done("silence");
		pay(120, 8'h00, 8'h00);
		chk(result.xformOnly, 32'h1);
		pay(160, 8'hE0, 8'h00);
		chk({result.hiqCore, result.prevLp, result.prevLpRateHigh}, 32'h7);
		pay(160, 8'hA0, 8'h00);
		chk({result.hiqCore, result.prevLp, result.prevLpRateHigh}, 32'h4);
		pay(160, 8'h5C, 8'h00);
		chk({result.hiqCore, result.chanIdx}, 32'h17);
		done("highrate");
		axw(`ADDR_CTRL, 32'h6);
		for (int j = 0; j < 8; j++) begin
			pay(33, 8'h48, {3'h0, 2'(j), 3'(j)});
			chk({result.chanIdx, result.redundFlag}, 32'h13);
			chk(result.redundOffset, od[j % 4]);
			chk(result.redundType, j);
		end
		pay(33, 8'h40, 8'h1B);
		chk({result.redundFlag, result.redundOffset, result.redundType}, 0);
		done("chanaware");
		axw(`ADDR_CTRL, 32'h3);
		pay(18, 8'h80, 8'h00);
		chk(result.kind, KIND_HDR_FULL);
		chk(result.hdrIsRequest, 32'h1);
		pay(18, 8'h00, 8'h00);
		chk(result.hdrIsRequest, 32'h0);
		axw(`ADDR_CTRL, 32'h2);
		pay(10, 8'h00, 8'h00);
		chk(result.kind, KIND_HDR_FULL);
		axw(`ADDR_CTRL, 32'h0);
		pay(10, 8'h00, 8'h00);
		chk(resError, 32'h1);
		axr(`ADDR_STATUS);
		chk(rd[31:16], 32'h1);
		done("headerfull");
		repeat (3) pulse(1'b0, 1'b0);
		chk(rtpTimestamp, 32'h3C0);
		axw(`ADDR_TSTAMP, 32'hFFFFFF00);
		pulse(1'b0, 1'b0);
		chk(rtpTimestamp, 32'h40);
		pulse(1'b1, 1'b1);
		chk(rtpMarker, 32'h1);
		pulse(1'b1, 1'b0);
		chk(rtpMarker, 32'h0);
		done("rtp");
		complete_run();
	end
endmodule : speech_payload_classifier_tb
`default_nettype wire
